/* File: common/pwm_timer_pkg.sv */
// Purpose: Shared constants for the 8-bit auto-reload PWM timer.
// Assumes: 32-bit APB register window, one aligned word per register.
// Notes: Narrow registers sit in the low byte; upper bits read as zero.
package pwm_timer_pkg;
  localparam int CNT_W     = 8;
  localparam int PRESC_W   = 7;
  localparam int DIV_W     = 3;
  localparam int NUM_PWM   = 4;
  localparam int NUM_CAP   = 2;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int SYNC_FILL = 3;

  localparam logic [ADDR_W-1:0] OFF_CTRL_STATUS  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_COUNTER      = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_RELOAD       = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_CTRL  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_DUTY0        = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_CTRL = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE0     = 12'h024;
  localparam logic [ADDR_W-1:0] REG_STRIDE       = 12'h004;

  localparam int CS_EXT_CLK = 7;
  localparam int CS_DIV_LSB = 4;
  localparam int CS_RUN     = 3;
  localparam int CS_FORCE   = 2;
  localparam int CS_OIE     = 1;
  localparam int CS_OVF     = 0;
  localparam int OC_OE_LSB  = 4;
  localparam int OC_POL_LSB = 0;
  localparam int CC_FLAG_LSB = 0;
  localparam int CC_IE_LSB   = 2;
  localparam int CC_EDGE_LSB = 4;

  localparam logic [CNT_W-1:0] RST_CTRL_STATUS  = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNTER      = 8'h00;
  localparam logic [CNT_W-1:0] RST_RELOAD       = 8'h00;
  localparam logic [CNT_W-1:0] RST_OUTPUT_CTRL  = 8'h00;
  localparam logic [CNT_W-1:0] RST_DUTY         = 8'h00;
  localparam logic [CNT_W-1:0] RST_CAPTURE_CTRL = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX          = 8'hFF;
endpackage

/* File: hdl/art_prescaler.sv */
// Purpose: Input clock select and 7-bit power-of-two prescaler.
// Assumes: External clock pin is asynchronous; sampled by two flops.
// Notes: An event is a rising edge of the synchronised pin.
module art_prescaler #(
  parameter int PRESC_W = pwm_timer_pkg::PRESC_W,
  parameter int DIV_W   = pwm_timer_pkg::DIV_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               external_clock_pin,
  input  wire logic               external_clock_select,
  input  wire logic               counter_run_enable,
  input  wire logic               halt_mode,
  input  wire logic [DIV_W-1:0]   clock_divide_select,
  input  wire logic               clear,
  output      logic               count_tick,
  output      logic [PRESC_W-1:0] presc_value
);
  logic               ext_meta_reg;
  logic               ext_sync_reg;
  logic               ext_prev_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic               in_tick;
  logic               active;

  function automatic logic [PRESC_W-1:0] tap_mask(input logic [DIV_W-1:0] sel);
    tap_mask = PRESC_W'((1 << sel) - 1);
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= external_clock_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign in_tick = external_clock_select ? (ext_sync_reg & ~ext_prev_reg) : 1'b1;
  // Halt freezes counting on either source, so no stray increments
  assign active  = counter_run_enable & ~halt_mode;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_reg <= '0;
    end else if (clear) begin
      presc_reg <= '0;
    end else if (active && in_tick) begin
      presc_reg <= PRESC_W'(presc_reg + 1'b1);
    end
  end

  // Tap n fires once per 2^n input events
  assign count_tick = active & in_tick & ~clear &
                      ((presc_reg & tap_mask(clock_divide_select)) ==
                       tap_mask(clock_divide_select));
  assign presc_value = presc_reg;
endmodule

/* File: hdl/art_capture.sv */
// Purpose: One input capture channel with edge select and lock.
// Assumes: Pin is asynchronous; read_clear is a one-cycle pulse.
// Notes: Edges are ignored until the synchroniser has filled.
module art_capture #(
  parameter int CNT_W = pwm_timer_pkg::CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             capture_input_pin,
  input  wire logic             rising_select,
  input  wire logic [CNT_W-1:0] counter,
  input  wire logic             read_clear,
  output      logic [CNT_W-1:0] capture_value,
  output      logic             capture_flag
);
  logic                                 meta_reg;
  logic                                 sync_reg;
  logic                                 prev_reg;
  logic [pwm_timer_pkg::SYNC_FILL-1:0]  fill_reg;
  logic                                 edge_hit;
  logic [CNT_W-1:0]                     value_reg;
  logic                                 flag_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      fill_reg <= '0;
    end else begin
      meta_reg <= capture_input_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      fill_reg <= {fill_reg[pwm_timer_pkg::SYNC_FILL-2:0], 1'b1};
    end
  end

  // Reset value of the chain must not look like an edge
  assign edge_hit = fill_reg[pwm_timer_pkg::SYNC_FILL-1] &
                    (rising_select ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= '0;
      flag_reg  <= 1'b0;
    end else if (edge_hit && (!flag_reg || read_clear)) begin
      value_reg <= counter;
      flag_reg  <= 1'b1;
    end else if (read_clear) begin
      flag_reg  <= 1'b0;
    end
  end

  assign capture_value = value_reg;
  assign capture_flag  = flag_reg;
endmodule

/* File: hdl/pwm_autoreload_timer.sv */
// Purpose: 8-bit auto-reload timer, four PWM channels, two captures, APB slave.
// Assumes: APB3 without wait states; pins asynchronous to clk.
// Notes: Read data is registered in the setup phase.
module pwm_autoreload_timer #(
  parameter int NUM_PWM = pwm_timer_pkg::NUM_PWM,
  parameter int NUM_CAP = pwm_timer_pkg::NUM_CAP
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [pwm_timer_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [pwm_timer_pkg::DATA_W-1:0]  pwdata,
  output      logic [pwm_timer_pkg::DATA_W-1:0]  prdata,
  output      logic                              pready,
  output      logic                              pslverr,
  input  wire logic                              external_clock_pin,
  input  wire logic [NUM_CAP-1:0]                capture_input_pin,
  input  wire logic                              halt_mode,
  output      logic [NUM_PWM-1:0]                pwm_output_pin,
  output      logic [NUM_PWM-1:0]                pwm_output_en,
  output      logic                              overflow_irq,
  output      logic [NUM_CAP-1:0]                capture_irq,
  output      logic                              wake_req
);
  localparam int CW = pwm_timer_pkg::CNT_W;
  localparam int AW = pwm_timer_pkg::ADDR_W;
  localparam int DW = pwm_timer_pkg::DATA_W;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic                         ext_sel_reg;
  logic [pwm_timer_pkg::DIV_W-1:0] div_sel_reg;
  logic                         run_reg;
  logic                         oie_reg;
  logic                         ovf_flag_reg;
  logic [CW-1:0]                counter_reg;
  logic [CW-1:0]                reload_value_reg;
  logic [CW-1:0]                output_ctrl_reg;
  logic [NUM_PWM-1:0][CW-1:0]   duty_cycle_reg;
  logic [NUM_PWM-1:0][CW-1:0]   compare_shadow_reg;
  logic [NUM_PWM-1:0]           pwm_level_reg;
  logic [NUM_CAP-1:0]           cap_ie_reg;
  logic [NUM_CAP-1:0]           cap_edge_reg;
  logic [DW-1:0]                prdata_reg;
  logic                         ovf_seen_reg;
  logic [NUM_CAP-1:0]           cap_seen_reg;

  logic                         setup;
  logic                         wr;
  logic                         rd;
  logic                         wr_ctrl;
  logic                         wr_counter;
  logic                         force_load;
  logic                         sw_load;
  logic                         count_tick;
  logic                         overflow;
  logic [pwm_timer_pkg::PRESC_W-1:0] presc_value;
  logic [NUM_CAP-1:0][CW-1:0]   cap_value;
  logic [NUM_CAP-1:0]           cap_flag;
  logic [NUM_CAP-1:0]           cap_read;
  logic [CW-1:0]                rd_value;
  logic [NUM_PWM-1:0]           polarity;

  function automatic logic [AW-1:0] duty_addr(input int idx);
    duty_addr = pwm_timer_pkg::OFF_DUTY0 + AW'(idx) * pwm_timer_pkg::REG_STRIDE;
  endfunction

  function automatic logic [AW-1:0] cap_addr(input int idx);
    cap_addr = pwm_timer_pkg::OFF_CAPTURE0 + AW'(idx) * pwm_timer_pkg::REG_STRIDE;
  endfunction

  function automatic logic addr_known(input logic [AW-1:0] a);
    addr_known = (a == pwm_timer_pkg::OFF_CTRL_STATUS) ||
                 (a == pwm_timer_pkg::OFF_COUNTER) ||
                 (a == pwm_timer_pkg::OFF_RELOAD) ||
                 (a == pwm_timer_pkg::OFF_OUTPUT_CTRL) ||
                 (a == pwm_timer_pkg::OFF_CAPTURE_CTRL);
    for (int i = 0; i < NUM_PWM; i++) begin
      if (a == duty_addr(i)) begin
        addr_known = 1'b1;
      end
    end
    for (int i = 0; i < NUM_CAP; i++) begin
      if (a == cap_addr(i)) begin
        addr_known = 1'b1;
      end
    end
  endfunction

  // Bus decode; every access completes in its first access cycle
  assign setup      = psel & ~penable;
  assign wr         = psel & penable & pwrite;
  assign rd         = psel & penable & ~pwrite;
  assign wr_ctrl    = wr && (paddr == pwm_timer_pkg::OFF_CTRL_STATUS);
  assign wr_counter = wr && (paddr == pwm_timer_pkg::OFF_COUNTER);
  assign force_load = wr_ctrl & pwdata[pwm_timer_pkg::CS_FORCE] &
                      pwdata[pwm_timer_pkg::CS_RUN];
  assign sw_load    = force_load | wr_counter;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~addr_known(paddr);
  assign prdata     = prdata_reg;

  art_prescaler u_prescaler (
    .clk                   (clk),
    .rst                   (rst),
    .external_clock_pin    (external_clock_pin),
    .external_clock_select (ext_sel_reg),
    .counter_run_enable    (run_reg),
    .halt_mode             (halt_mode),
    .clock_divide_select   (div_sel_reg),
    .clear                 (sw_load),
    .count_tick            (count_tick),
    .presc_value           (presc_value)
  );

  // Software loads suppress the tick, so overflow never races a write
  assign overflow = count_tick && (counter_reg == pwm_timer_pkg::CNT_MAX);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_sel_reg <= pwm_timer_pkg::RST_CTRL_STATUS[pwm_timer_pkg::CS_EXT_CLK];
      div_sel_reg <= pwm_timer_pkg::RST_CTRL_STATUS[pwm_timer_pkg::CS_DIV_LSB +:
                                                    pwm_timer_pkg::DIV_W];
      run_reg     <= pwm_timer_pkg::RST_CTRL_STATUS[pwm_timer_pkg::CS_RUN];
      oie_reg     <= pwm_timer_pkg::RST_CTRL_STATUS[pwm_timer_pkg::CS_OIE];
    end else if (wr_ctrl) begin
      ext_sel_reg <= pwdata[pwm_timer_pkg::CS_EXT_CLK];
      div_sel_reg <= pwdata[pwm_timer_pkg::CS_DIV_LSB +: pwm_timer_pkg::DIV_W];
      run_reg     <= pwdata[pwm_timer_pkg::CS_RUN];
      oie_reg     <= pwdata[pwm_timer_pkg::CS_OIE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_reg <= pwm_timer_pkg::RST_COUNTER;
    end else if (wr_counter) begin
      counter_reg <= pwdata[CW-1:0];
    end else if (force_load || overflow) begin
      counter_reg <= reload_value_reg;
    end else if (count_tick) begin
      counter_reg <= CW'(counter_reg + 1'b1);
    end
  end

  chk_count_step: assert property (
    count_tick && !sw_load && counter_reg != pwm_timer_pkg::CNT_MAX
    |=> counter_reg == $past(counter_reg) + 8'h01)
    else $error("counter did not step by one on a tick");

  chk_overflow_reload: assert property (
    overflow |=> counter_reg == $past(reload_value_reg) &&
                 presc_value == $past(presc_value) + 7'h01)
    else $error("overflow did not reload counter or disturbed prescaler");

  chk_stopped_hold: assert property (
    !run_reg && !sw_load |=> $stable(counter_reg) && $stable(presc_value))
    else $error("counter or prescaler moved while stopped");

  chk_force_reload: assert property (
    force_load |=> counter_reg == $past(reload_value_reg) && presc_value == 7'h00)
    else $error("force reload did not load counter and clear prescaler");

  chk_counter_write: assert property (
    wr_counter |=> counter_reg == $past(pwdata[7:0]) && presc_value == 7'h00)
    else $error("counter write did not take value or clear prescaler");

  chk_halt_freeze: assert property (
    halt_mode && !sw_load |=> $stable(counter_reg))
    else $error("counter moved during halt");

  // Flag clears only if the read actually returned it set, so a late set is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_flag_reg <= pwm_timer_pkg::RST_CTRL_STATUS[pwm_timer_pkg::CS_OVF];
    end else if (overflow) begin
      ovf_flag_reg <= 1'b1;
    end else if (rd && paddr == pwm_timer_pkg::OFF_CTRL_STATUS && ovf_seen_reg) begin
      ovf_flag_reg <= 1'b0;
    end
  end

  assign overflow_irq = ovf_flag_reg & oie_reg;

  chk_overflow_flag: assert property (
    overflow |=> ovf_flag_reg && (overflow_irq == oie_reg))
    else $error("overflow did not set flag or interrupt");

  chk_flag_read_clear: assert property (
    rd && paddr == pwm_timer_pkg::OFF_CTRL_STATUS && prdata_reg[0] && !overflow
    |=> !ovf_flag_reg)
    else $error("status read did not clear overflow flag");

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_value_reg <= pwm_timer_pkg::RST_RELOAD;
      output_ctrl_reg  <= pwm_timer_pkg::RST_OUTPUT_CTRL;
      cap_ie_reg       <= pwm_timer_pkg::RST_CAPTURE_CTRL[pwm_timer_pkg::CC_IE_LSB +: NUM_CAP];
      cap_edge_reg     <= pwm_timer_pkg::RST_CAPTURE_CTRL[pwm_timer_pkg::CC_EDGE_LSB +: NUM_CAP];
    end else begin
      if (wr && paddr == pwm_timer_pkg::OFF_RELOAD) begin
        reload_value_reg <= pwdata[CW-1:0];
      end
      if (wr && paddr == pwm_timer_pkg::OFF_OUTPUT_CTRL) begin
        output_ctrl_reg <= pwdata[CW-1:0];
      end
      if (wr && paddr == pwm_timer_pkg::OFF_CAPTURE_CTRL) begin
        cap_ie_reg   <= pwdata[pwm_timer_pkg::CC_IE_LSB +: NUM_CAP];
        cap_edge_reg <= pwdata[pwm_timer_pkg::CC_EDGE_LSB +: NUM_CAP];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PWM; i++) begin
        duty_cycle_reg[i] <= pwm_timer_pkg::RST_DUTY;
      end
    end else begin
      for (int i = 0; i < NUM_PWM; i++) begin
        if (wr && paddr == duty_addr(i)) begin
          duty_cycle_reg[i] <= pwdata[CW-1:0];
        end
      end
    end
  end

  // Shadow copy keeps a mid-period duty change from glitching the output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compare_shadow_reg <= '0;
    end else if (overflow) begin
      compare_shadow_reg <= duty_cycle_reg;
    end
  end

  chk_shadow_load: assert property (
    overflow |=> compare_shadow_reg == $past(duty_cycle_reg))
    else $error("compare shadow not loaded at overflow");

  chk_shadow_hold: assert property (
    !overflow |=> $stable(compare_shadow_reg))
    else $error("compare shadow changed without overflow");

  // Raw level is high while counter is at or below compare; overflow has priority
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_level_reg <= '1;
    end else begin
      for (int i = 0; i < NUM_PWM; i++) begin
        if (overflow) begin
          pwm_level_reg[i] <= 1'b1;
        end else if (count_tick && !sw_load && counter_reg == compare_shadow_reg[i]) begin
          pwm_level_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Polarity acts combinationally so a change shows at once
  assign polarity       = output_ctrl_reg[pwm_timer_pkg::OC_POL_LSB +: NUM_PWM];
  assign pwm_output_en  = output_ctrl_reg[pwm_timer_pkg::OC_OE_LSB +: NUM_PWM];
  assign pwm_output_pin = pwm_output_en & (pwm_level_reg ^ polarity);

  chk_pwm_overflow: assert property (
    overflow |=> pwm_level_reg == 4'hF)
    else $error("PWM levels not set at overflow");

  chk_pwm_match: assert property (
    count_tick && !overflow && !sw_load && counter_reg == compare_shadow_reg[0]
    |=> !pwm_level_reg[0] && (pwm_output_pin[0] == (pwm_output_en[0] & polarity[0])))
    else $error("channel 0 did not return level on compare match");

  for (genvar c = 0; c < NUM_CAP; c++) begin : g_cap
    art_capture u_capture (
      .clk               (clk),
      .rst               (rst),
      .capture_input_pin (capture_input_pin[c]),
      .rising_select     (cap_edge_reg[c]),
      .counter           (counter_reg),
      .read_clear        (cap_read[c]),
      .capture_value     (cap_value[c]),
      .capture_flag      (cap_flag[c])
    );
    assign cap_read[c] = rd && (paddr == cap_addr(c)) && cap_seen_reg[c];
  end

  assign capture_irq = cap_flag & cap_ie_reg;
  // Capture logic runs in halt, so it can still wake the core
  assign wake_req    = |capture_irq;

  chk_capture_lock: assert property (
    cap_flag[0] && !cap_read[0] |=> $stable(cap_value[0]) && cap_flag[0])
    else $error("capture 0 changed while locked");

  chk_capture_irq: assert property (
    cap_flag[1] && cap_ie_reg[1] && !cap_read[1] &&
    !(wr && paddr == pwm_timer_pkg::OFF_CAPTURE_CTRL) |=> capture_irq[1] && wake_req)
    else $error("capture 1 interrupt dropped while pending");

  always_comb begin
    rd_value = '0;
    case (paddr)
      pwm_timer_pkg::OFF_CTRL_STATUS: begin
        rd_value[pwm_timer_pkg::CS_EXT_CLK] = ext_sel_reg;
        rd_value[pwm_timer_pkg::CS_DIV_LSB +: pwm_timer_pkg::DIV_W] = div_sel_reg;
        rd_value[pwm_timer_pkg::CS_RUN] = run_reg;
        rd_value[pwm_timer_pkg::CS_FORCE] = 1'b0;
        rd_value[pwm_timer_pkg::CS_OIE] = oie_reg;
        rd_value[pwm_timer_pkg::CS_OVF] = ovf_flag_reg;
      end
      pwm_timer_pkg::OFF_COUNTER:     rd_value = counter_reg;
      pwm_timer_pkg::OFF_RELOAD:      rd_value = reload_value_reg;
      pwm_timer_pkg::OFF_OUTPUT_CTRL: rd_value = output_ctrl_reg;
      pwm_timer_pkg::OFF_CAPTURE_CTRL: begin
        rd_value[pwm_timer_pkg::CC_FLAG_LSB +: NUM_CAP] = cap_flag;
        rd_value[pwm_timer_pkg::CC_IE_LSB +: NUM_CAP]   = cap_ie_reg;
        rd_value[pwm_timer_pkg::CC_EDGE_LSB +: NUM_CAP] = cap_edge_reg;
      end
      default: rd_value = '0;
    endcase
    for (int i = 0; i < NUM_PWM; i++) begin
      if (paddr == duty_addr(i)) begin
        rd_value = duty_cycle_reg[i];
      end
    end
    for (int i = 0; i < NUM_CAP; i++) begin
      if (paddr == cap_addr(i)) begin
        rd_value = cap_value[i];
      end
    end
  end

  // Snapshot taken in setup; the flags seen here decide what a read may clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_reg   <= '0;
      ovf_seen_reg <= 1'b0;
      cap_seen_reg <= '0;
    end else if (setup) begin
      prdata_reg   <= {{(DW-CW){1'b0}}, rd_value};
      ovf_seen_reg <= ovf_flag_reg;
      cap_seen_reg <= cap_flag;
    end
  end

  chk_force_reads_zero: assert property (
    setup && paddr == pwm_timer_pkg::OFF_CTRL_STATUS |=> prdata_reg[2] == 1'b0)
    else $error("force reload bit read back as one");

  chk_counter_read: assert property (
    setup && paddr == pwm_timer_pkg::OFF_COUNTER |=> prdata_reg[7:0] == $past(counter_reg))
    else $error("counter read did not return live value");
endmodule

/* File: verif/art_pin_model.sv */
// Purpose: Pin-side model: event clock and capture inputs.
// Assumes: Called right after a clk edge; pins idle low.
// Notes: Event clock only moves inside a burst, never free-running.
module art_pin_model (
  input  wire logic       clk,
  output      logic       external_clock_pin,
  output      logic [1:0] capture_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    external_clock_pin = 1'b0;
    capture_input_pin  = 2'b00;
  end
  // Four clocks per level so the two-flop synchroniser sees each event
  task automatic burst(input int n);
    repeat (n) begin
      external_clock_pin <= 1'b1;
      repeat (4) @(posedge clk);
      external_clock_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic cap_rise(input int ch);
    capture_input_pin[ch] <= 1'b1;
    @(posedge clk);
  endtask
endmodule

/* File: verif/pwm_autoreload_timer_tb.sv */
// Purpose: Self-checking bench for the auto-reload PWM timer.
// Assumes: APB slave answers with pready; halt raised only once counting stops.
// Notes: Reads queue their expectation; a monitor compares on completion.
module pwm_autoreload_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, halt_mode = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h55;
  logic pready, pslverr, external_clock_pin, overflow_irq, wake_req;
  logic [1:0] capture_input_pin, capture_irq;
  logic [3:0] pwm_output_pin, pwm_output_en;
  logic [31:0] exp_q[$];
  logic err_q[$];
  logic [7:0] v;
  int n_mismatch = 0, cmp_count = 0;
  pwm_autoreload_timer dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_pin(external_clock_pin),
    .capture_input_pin(capture_input_pin), .halt_mode(halt_mode),
    .pwm_output_pin(pwm_output_pin), .pwm_output_en(pwm_output_en),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq), .wake_req(wake_req));
  art_pin_model pins (.clk(clk), .external_clock_pin(external_clock_pin),
    .capture_input_pin(capture_input_pin));
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin n_mismatch++; report_and_stop(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic se = 1'b0);
    exp_q.push_back(e);
    err_q.push_back(se);
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk("prdata", exp_q.pop_front(), prdata);
      chk("pslverr", {31'h0, err_q.pop_front()}, {31'h0, pslverr});
    end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(pwm_timer_pkg::OFF_CTRL_STATUS, 32'h0);
    v = 8'(xs());
    apb(1'b1, pwm_timer_pkg::OFF_COUNTER, {24'h0, v});
    repeat (5) @(posedge clk);
    rd(pwm_timer_pkg::OFF_COUNTER, {24'h0, v});
    rd(12'h100, 32'h0, 1'b1);
    apb(1'b1, pwm_timer_pkg::OFF_CAPTURE_CTRL, 32'h14);
    pins.cap_rise(0);
    repeat (6) @(posedge clk);
    chk("cap_irq", {29'h0, wake_req, capture_irq}, 32'h5);
    rd(pwm_timer_pkg::OFF_CAPTURE_CTRL, 32'h15);
    rd(pwm_timer_pkg::OFF_CAPTURE0, {24'h0, v});
    rd(pwm_timer_pkg::OFF_CAPTURE_CTRL, 32'h14);
    apb(1'b1, pwm_timer_pkg::OFF_RELOAD, 32'hFD);
    apb(1'b1, pwm_timer_pkg::OFF_CTRL_STATUS, 32'h8E);
    pins.burst(3);
    repeat (4) @(posedge clk);
    chk("ovf_irq", {31'h0, overflow_irq}, 32'h1);
    rd(pwm_timer_pkg::OFF_CTRL_STATUS, 32'h8B);
    rd(pwm_timer_pkg::OFF_CTRL_STATUS, 32'h8A);
    rd(pwm_timer_pkg::OFF_COUNTER, 32'hFD);
    apb(1'b1, pwm_timer_pkg::OFF_OUTPUT_CTRL, 32'hA0);
    chk("pwm_en", {28'h0, pwm_output_en}, 32'hA);
    apb(1'b1, pwm_timer_pkg::OFF_OUTPUT_CTRL, 32'h10);
    apb(1'b1, pwm_timer_pkg::OFF_DUTY0, 32'hFE);
    pins.burst(3);
    chk("pwm_pin", {28'h0, pwm_output_pin}, 32'h1);
    pins.burst(1);
    chk("pwm_pin", {28'h0, pwm_output_pin}, 32'h1);
    pins.burst(1);
    chk("pwm_pin", {28'h0, pwm_output_pin}, 32'h0);
    apb(1'b1, pwm_timer_pkg::OFF_OUTPUT_CTRL, 32'h11);
    chk("pwm_pin", {28'h0, pwm_output_pin}, 32'h1);
    pins.burst(1);
    chk("pwm_pin", {28'h0, pwm_output_pin}, 32'h0);
    rd(pwm_timer_pkg::OFF_COUNTER, 32'hFD);
    apb(1'b1, pwm_timer_pkg::OFF_CTRL_STATUS, 32'h80);
    apb(1'b1, pwm_timer_pkg::OFF_CAPTURE_CTRL, 32'h28);
    halt_mode <= 1'b1;
    pins.cap_rise(1);
    pins.burst(1);
    chk("wake", {29'h0, wake_req, capture_irq}, 32'h6);
    rd(pwm_timer_pkg::OFF_CAPTURE0 + 12'h004, 32'hFD);
    report_and_stop();
  end
endmodule
